// *** core/spr_pkg.sv ***
// constants, carriers and enums for the special purpose register block
// assumes one core clock and an Avalon-MM master with byte addresses
//
// Operation
// - data address is page-high byte over one of two offset-low bytes
// - two full index banks, active one picked by index bank select bit
// - link branch saves pc into link ext, high and low
// - link return reloads pc from link ext, high and low
// - code loads read program word at link address into table buffer
// - incrementing code load bumps link low afterwards, plain load does not
// - narrow program space forces pc and program address top nibble inactive
// - narrow program space skips link ext on link branch and return
// - direct addressing uses page zero or active page-high per select bit
// - global enable low masks interrupt 0 and interrupt 1
// - interrupt entry clears global enable
// - interrupt return sets global enable
// - bank select bits steer index bank and general register bank
// - stack exception raised only while its enable bit is set
// - per-interrupt enables, both ignored while global enable is low
// - alu carry held in status bit 0
// - overflow is carry into msb differing from carry out
// - zero flag set exactly when alu result is zero
// - negative flag takes result msb, loads count as alu operations
// - overflow-updating operations set negative to overflow xor msb
// - stack fault flag set on stack overflow or underflow
package spr_pkg;

    localparam int SPR_AW = 6;
    localparam int SPR_PCW = 20;

    // register byte offsets
    localparam logic [5:0] OFS_INDEX_PAGE_HIGH = 6'h00;
    localparam logic [5:0] OFS_INDEX_OFFSET_LOW0 = 6'h04;
    localparam logic [5:0] OFS_INDEX_OFFSET_LOW1 = 6'h08;
    localparam logic [5:0] OFS_LINK_EXT = 6'h0C;
    localparam logic [5:0] OFS_LINK_HIGH = 6'h10;
    localparam logic [5:0] OFS_LINK_LOW = 6'h14;
    localparam logic [5:0] OFS_TABLE_BUF_HIGH = 6'h18;
    localparam logic [5:0] OFS_TABLE_BUF_LOW = 6'h1C;
    localparam logic [5:0] OFS_SYSTEM_CONTROL_STATUS = 6'h20;
    localparam logic [5:0] OFS_ALU_STATUS = 6'h24;

    // system_control_status fields
    localparam int SCS_DIRECT_PAGE_SEL = 0;
    localparam int SCS_GLOBAL_IRQ_ENABLE = 1;
    localparam int SCS_INDEX_BANK_SEL = 2;
    localparam int SCS_GPR_BANK_LO = 3;
    localparam int SCS_GPR_BANK_HI = 4;
    localparam int SCS_STACK_EXC_ENABLE = 5;
    localparam int SCS_IRQ0_ENABLE = 6;
    localparam int SCS_IRQ1_ENABLE = 7;

    // alu_status fields
    localparam int ALS_CARRY = 0;
    localparam int ALS_OVERFLOW = 1;
    localparam int ALS_ZERO = 2;
    localparam int ALS_NEGATIVE = 3;
    localparam int ALS_STACK_FAULT = 4;
    localparam logic [7:0] ALS_WRITABLE = 8'h1F;

    // reset values
    localparam logic [7:0] RST_SYSTEM_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] RST_ALU_STATUS = 8'h00;
    localparam logic [7:0] RST_SPR = 8'h00;

    // alu result as offered by the execute stage
    typedef struct packed {
        logic upd;
        logic arith;
        logic [7:0] result;
        logic carry_out;
        logic carry_msb;
    } spr_alu_t;

    // one-cycle instruction strobes from decode
    typedef struct packed {
        logic link_branch_instr;
        logic link_return_instr;
        logic code_load_instr;
        logic code_load_inc_instr;
        logic irq_enter;
        logic irq_return_instr;
    } spr_ctl_t;

    typedef enum logic [1:0] {SPR_AM_IDX0, SPR_AM_IDX1, SPR_AM_DIRECT} spr_amode_t;
    typedef enum logic {SPR_BUS_IDLE, SPR_BUS_ACK} spr_bus_t;

endpackage

// *** core/spr_flags.sv ***
// alu flag next-value logic for alu_status bits 3..0
// assumes the execute stage supplies result, carry out and carry into msb
module spr_flags
    import spr_pkg::*;
(
    // alu side
    input spr_alu_t alu,
    // current and next carry, overflow, zero, negative
    input logic [3:0] cur,
    output logic [3:0] nxt
);

    logic ovf;

    always_comb begin
        ovf = alu.carry_msb ^ alu.carry_out;
        nxt = cur;
        if (alu.upd) begin
            nxt[ALS_ZERO] = (alu.result == 8'h00);
            // loads and logic ops keep carry and overflow
            nxt[ALS_NEGATIVE] = alu.result[7];
            if (alu.arith) begin
                nxt[ALS_CARRY] = alu.carry_out;
                nxt[ALS_OVERFLOW] = ovf;
                nxt[ALS_NEGATIVE] = ovf ^ alu.result[7];
            end
        end
    end

endmodule

// *** core/spr_regs.sv ***
// special purpose registers: index banks, link, table buffer, two status regs
// assumes decode strobes last one cycle and program data is valid with the strobe
module spr_regs
    import spr_pkg::*;
(
    // clock and reset
    input logic CORE_CLK,
    input logic RST_B,
    // avalon-mm slave
    input logic [SPR_AW-1:0] AVS_ADDRESS,
    input logic AVS_READ,
    input logic AVS_WRITE,
    input logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // decode and execute
    input spr_ctl_t CTL,
    input spr_alu_t ALU,
    input logic [SPR_PCW-1:0] PC_IN,
    output logic [SPR_PCW-1:0] PC_RESTORE,
    // program memory
    input logic NARROW_PROG_SPACE_N,
    output logic [SPR_PCW-1:0] PROG_ADDR_OUT,
    output logic CODE_RD,
    input logic [15:0] PROG_DATA,
    // data memory addressing
    input spr_amode_t ADDR_MODE,
    input logic [7:0] DIRECT_OFFSET,
    output logic [15:0] DATA_ADDR,
    output logic [1:0] GPR_BANK,
    // interrupts and stack
    input logic IRQ0_REQ,
    input logic IRQ1_REQ,
    output logic IRQ0_TAKE,
    output logic IRQ1_TAKE,
    input logic STACK_OVF,
    input logic STACK_UNF,
    output logic STACK_EXC
);

    spr_bus_t bus_ff;
    logic [7:0] idh_ff [2];
    logic [7:0] index_offset_low0_ff [2];
    logic [7:0] index_offset_low1_ff [2];
    logic [3:0] link_ext_ff;
    logic [7:0] link_high_ff;
    logic [7:0] link_low_ff;
    logic [7:0] tbh_ff;
    logic [7:0] tbl_ff;
    logic [7:0] scs_ff;
    logic [7:0] als_ff;
    logic [31:0] rdata_ff;
    logic [SPR_PCW-1:0] pa_ff;
    logic [15:0] daddr_ff;
    logic irq0_ff;
    logic irq1_ff;
    logic sexc_ff;
    logic bank;
    logic wide;
    logic wr_go;
    logic [7:0] wb;
    logic [7:0] rsel;
    logic [3:0] nxt_flags;
    logic stack_ev;
    logic code_ld;

    assign bank = scs_ff[SCS_INDEX_BANK_SEL];
    assign wide = NARROW_PROG_SPACE_N;
    assign wb = AVS_WRITEDATA[7:0];
    assign stack_ev = STACK_OVF | STACK_UNF;
    assign code_ld = CTL.code_load_instr | CTL.code_load_inc_instr;

    // one wait cycle per access; the write lands on the edge after the one that ends the wait
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & (bus_ff == SPR_BUS_IDLE);
    assign wr_go = AVS_WRITE & (bus_ff == SPR_BUS_ACK);

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            bus_ff <= SPR_BUS_IDLE;
        end else begin
            case (bus_ff)
                SPR_BUS_IDLE: begin
                    if (AVS_READ | AVS_WRITE) begin
                        bus_ff <= SPR_BUS_ACK;
                    end
                end
                default: begin
                    bus_ff <= SPR_BUS_IDLE;
                end
            endcase
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        if (AVS_ADDRESS == OFS_INDEX_PAGE_HIGH) begin
            rsel = idh_ff[bank];
        end else if (AVS_ADDRESS == OFS_INDEX_OFFSET_LOW0) begin
            rsel = index_offset_low0_ff[bank];
        end else if (AVS_ADDRESS == OFS_INDEX_OFFSET_LOW1) begin
            rsel = index_offset_low1_ff[bank];
        end else if (AVS_ADDRESS == OFS_LINK_EXT) begin
            rsel = {4'h0, link_ext_ff};
        end else if (AVS_ADDRESS == OFS_LINK_HIGH) begin
            rsel = link_high_ff;
        end else if (AVS_ADDRESS == OFS_LINK_LOW) begin
            rsel = link_low_ff;
        end else if (AVS_ADDRESS == OFS_TABLE_BUF_HIGH) begin
            rsel = tbh_ff;
        end else if (AVS_ADDRESS == OFS_TABLE_BUF_LOW) begin
            rsel = tbl_ff;
        end else if (AVS_ADDRESS == OFS_SYSTEM_CONTROL_STATUS) begin
            rsel = scs_ff;
        end else if (AVS_ADDRESS == OFS_ALU_STATUS) begin
            rsel = als_ff;
        end else begin
            rsel = 8'h00;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_ff <= 32'h0000_0000;
        end else if (AVS_READ & (bus_ff == SPR_BUS_IDLE)) begin
            rdata_ff <= {24'h00_0000, rsel};
        end
    end

    assign AVS_READDATA = rdata_ff;

    // index banks; software reaches only the active bank
    generate
        for (genvar b = 0; b < 2; b++) begin : g_bank
            always_ff @(posedge CORE_CLK or negedge RST_B) begin
                if (!RST_B) begin
                    idh_ff[b] <= RST_SPR;
                    index_offset_low0_ff[b] <= RST_SPR;
                    index_offset_low1_ff[b] <= RST_SPR;
                end else if (wr_go && (bank == 1'(b))) begin
                    if (AVS_ADDRESS == OFS_INDEX_PAGE_HIGH) begin
                        idh_ff[b] <= wb;
                    end else if (AVS_ADDRESS == OFS_INDEX_OFFSET_LOW0) begin
                        index_offset_low0_ff[b] <= wb;
                    end else if (AVS_ADDRESS == OFS_INDEX_OFFSET_LOW1) begin
                        index_offset_low1_ff[b] <= wb;
                    end
                end
            end
        end
    endgenerate

    // link registers; decode strobes outrank a bus write in the same cycle
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            link_ext_ff <= 4'h0;
            link_high_ff <= RST_SPR;
            link_low_ff <= RST_SPR;
        end else if (CTL.link_branch_instr) begin
            if (wide) begin
                link_ext_ff <= PC_IN[19:16];
            end
            link_high_ff <= PC_IN[15:8];
            link_low_ff <= PC_IN[7:0];
        end else if (CTL.code_load_inc_instr) begin
            link_low_ff <= link_low_ff + 8'h01;
        end else if (wr_go) begin
            if (AVS_ADDRESS == OFS_LINK_EXT) begin
                link_ext_ff <= wb[3:0];
            end else if (AVS_ADDRESS == OFS_LINK_HIGH) begin
                link_high_ff <= wb;
            end else if (AVS_ADDRESS == OFS_LINK_LOW) begin
                link_low_ff <= wb;
            end
        end
    end

    // return target; the top nibble stays idle in the narrow space
    assign PC_RESTORE = {wide ? link_ext_ff : 4'h0, link_high_ff, link_low_ff};

    // code reads use the link address in place of the pc
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pa_ff <= '0;
        end else if (code_ld) begin
            pa_ff <= {wide ? link_ext_ff : 4'h0, link_high_ff, link_low_ff};
        end else begin
            pa_ff <= {wide ? PC_IN[19:16] : 4'h0, PC_IN[15:0]};
        end
    end

    assign PROG_ADDR_OUT = pa_ff;
    assign CODE_RD = code_ld;

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            tbh_ff <= RST_SPR;
            tbl_ff <= RST_SPR;
        end else if (code_ld) begin
            tbh_ff <= PROG_DATA[15:8];
            tbl_ff <= PROG_DATA[7:0];
        end else if (wr_go) begin
            if (AVS_ADDRESS == OFS_TABLE_BUF_HIGH) begin
                tbh_ff <= wb;
            end else if (AVS_ADDRESS == OFS_TABLE_BUF_LOW) begin
                tbl_ff <= wb;
            end
        end
    end

    // system control/status; interrupt entry wins over return and bus
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            scs_ff <= RST_SYSTEM_CONTROL_STATUS;
        end else begin
            if (wr_go && (AVS_ADDRESS == OFS_SYSTEM_CONTROL_STATUS)) begin
                scs_ff <= wb;
            end
            if (CTL.irq_enter) begin
                scs_ff[SCS_GLOBAL_IRQ_ENABLE] <= 1'b0;
            end else if (CTL.irq_return_instr) begin
                scs_ff[SCS_GLOBAL_IRQ_ENABLE] <= 1'b1;
            end
        end
    end

    // nothing here saves the status regs on entry; handlers must do it
    assign GPR_BANK = scs_ff[SCS_GPR_BANK_HI:SCS_GPR_BANK_LO];

    spr_flags u_flags (
        .alu(ALU),
        .cur(als_ff[3:0]),
        .nxt(nxt_flags)
    );

    // alu_status; a stack event beats a clearing write
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            als_ff <= RST_ALU_STATUS;
        end else begin
            if (ALU.upd) begin
                als_ff[3:0] <= nxt_flags;
            end else if (wr_go && (AVS_ADDRESS == OFS_ALU_STATUS)) begin
                als_ff[3:0] <= wb[3:0];
            end
            if (stack_ev) begin
                als_ff[ALS_STACK_FAULT] <= 1'b1;
            end else if (wr_go && (AVS_ADDRESS == OFS_ALU_STATUS)) begin
                als_ff[ALS_STACK_FAULT] <= wb[ALS_STACK_FAULT];
            end
            als_ff[7:5] <= 3'b000;
        end
    end

    // data address, registered so the memory sees a clean bus
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            daddr_ff <= 16'h0000;
        end else begin
            case (ADDR_MODE)
                SPR_AM_IDX0: daddr_ff <= {idh_ff[bank], index_offset_low0_ff[bank]};
                SPR_AM_IDX1: daddr_ff <= {idh_ff[bank], index_offset_low1_ff[bank]};
                default: begin
                    if (scs_ff[SCS_DIRECT_PAGE_SEL]) begin
                        daddr_ff <= {idh_ff[bank], DIRECT_OFFSET};
                    end else begin
                        daddr_ff <= {8'h00, DIRECT_OFFSET};
                    end
                end
            endcase
        end
    end

    assign DATA_ADDR = daddr_ff;

    // interrupt gating and stack exception
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq0_ff <= 1'b0;
            irq1_ff <= 1'b0;
            sexc_ff <= 1'b0;
        end else begin
            irq0_ff <= IRQ0_REQ & scs_ff[SCS_IRQ0_ENABLE] & scs_ff[SCS_GLOBAL_IRQ_ENABLE];
            irq1_ff <= IRQ1_REQ & scs_ff[SCS_IRQ1_ENABLE] & scs_ff[SCS_GLOBAL_IRQ_ENABLE];
            sexc_ff <= stack_ev & scs_ff[SCS_STACK_EXC_ENABLE];
        end
    end

    assign IRQ0_TAKE = irq0_ff;
    assign IRQ1_TAKE = irq1_ff;
    assign STACK_EXC = sexc_ff;

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    link_save_a: assert property (CTL.link_branch_instr && wide |=>
        {link_ext_ff, link_high_ff, link_low_ff} == $past(PC_IN))
        else $error("link branch did not save pc");
    narrow_save_a: assert property (CTL.link_branch_instr && !wide |=>
        $stable(link_ext_ff))
        else $error("link ext changed in narrow space");
    ret_target_a: assert property (PC_RESTORE[15:0] == {link_high_ff, link_low_ff} &&
        (wide || PC_RESTORE[19:16] == 4'h0))
        else $error("return target wrong");
    pa_narrow_a: assert property (!wide |=> PROG_ADDR_OUT[19:16] == 4'h0)
        else $error("program address top nibble active");
    load_inc_a: assert property (CTL.code_load_inc_instr && !CTL.link_branch_instr |=>
        link_low_ff == $past(link_low_ff) + 8'h01)
        else $error("link low not incremented");
    tb_load_a: assert property (code_ld |=> {tbh_ff, tbl_ff} == $past(PROG_DATA))
        else $error("table buffer not loaded");
    irq_mask_a: assert property (!scs_ff[SCS_GLOBAL_IRQ_ENABLE] |=> !IRQ0_TAKE && !IRQ1_TAKE)
        else $error("interrupt passed while masked");
    ie_clear_a: assert property (CTL.irq_enter |=> !scs_ff[SCS_GLOBAL_IRQ_ENABLE])
        else $error("entry did not clear global enable");
    ie_set_a: assert property (CTL.irq_return_instr && !CTL.irq_enter |=>
        scs_ff[SCS_GLOBAL_IRQ_ENABLE])
        else $error("return did not set global enable");
    stack_exc_a: assert property (stack_ev |=> STACK_EXC == $past(scs_ff[SCS_STACK_EXC_ENABLE]))
        else $error("stack exception gating wrong");
    zero_flag_a: assert property (ALU.upd |=> als_ff[ALS_ZERO] == ($past(ALU.result) == 8'h00))
        else $error("zero flag wrong");
    carry_flag_a: assert property (ALU.upd && ALU.arith |=>
        als_ff[ALS_CARRY] == $past(ALU.carry_out))
        else $error("carry flag wrong");
    ovf_flag_a: assert property (ALU.upd && ALU.arith |=>
        als_ff[ALS_OVERFLOW] == $past(ALU.carry_msb ^ ALU.carry_out))
        else $error("overflow flag wrong");
    neg_flag_a: assert property (ALU.upd |=> als_ff[ALS_NEGATIVE] ==
        $past(ALU.result[7] ^ (ALU.arith & (ALU.carry_msb ^ ALU.carry_out))))
        else $error("negative flag wrong");
    page_zero_a: assert property (ADDR_MODE == SPR_AM_DIRECT && !scs_ff[SCS_DIRECT_PAGE_SEL] |=>
        DATA_ADDR[15:8] == 8'h00)
        else $error("direct page not zero");
    sf_sticky_a: assert property (als_ff[ALS_STACK_FAULT] && !wr_go |=> als_ff[ALS_STACK_FAULT])
        else $error("stack fault flag dropped");
    sf_set_a: assert property (stack_ev |=> als_ff[ALS_STACK_FAULT])
        else $error("stack fault flag not set");
    rsv_zero_a: assert property (als_ff[7:5] == 3'b000)
        else $error("reserved status bits nonzero");

    link_round_c: cover property (CTL.link_branch_instr ##[1:20] CTL.link_return_instr);
    load_inc_c: cover property (CTL.code_load_inc_instr ##1 CTL.code_load_inc_instr);
    irq_round_c: cover property (IRQ0_TAKE ##[1:20] CTL.irq_return_instr);
    bus_write_c: cover property (wr_go && AVS_ADDRESS == OFS_SYSTEM_CONTROL_STATUS);

endmodule

// *** verification/spr_core_model.sv ***
// program memory stand-in for the core sequencer side of the register block
// assumes the bench hands over the link address it expects a code load to use
module spr_core_model (
    // clock
    input logic clk,
    // code read
    input logic code_rd,
    input logic [19:0] link_addr,
    output logic [15:0] prog_data
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] idle_ff = 16'hA5A5;

    // released bus wanders every cycle, so a late sample cannot pass by luck
    always @(posedge clk) begin
        idle_ff <= ~idle_ff + 16'h1357;
    end

    // zero-latency memory: word is a fixed scramble of its address
    assign prog_data = code_rd ? (link_addr[15:0] ^ 16'hC3A5 ^ {12'h0, link_addr[19:16]})
                               : idle_ff;
endmodule

// *** verification/test_cpu_special_purpose_regs.sv ***
// self-checking bench for the special purpose register block
// assumes spr_pkg and spr_regs are compiled first, one core clock at 10 MHz
module test_cpu_special_purpose_regs
    import spr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {logic [5:0] a; logic [7:0] d; logic [7:0] q;} spr_row_t;

    // strobe codes in spr_ctl_t field order
    localparam logic [5:0] K_LINK = 6'h20;
    localparam logic [5:0] K_RET = 6'h10;
    localparam logic [5:0] K_LD = 6'h08;
    localparam logic [5:0] K_LDI = 6'h04;
    localparam logic [5:0] K_ENT = 6'h02;
    localparam logic [5:0] K_IRQ_RETURN_INSTR = 6'h01;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [5:0] addr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wait_req;
    spr_ctl_t ctl = '0;
    spr_alu_t alu = '0;
    logic [19:0] pc = 20'h0;
    logic [19:0] pc_rst;
    logic narrow_n = 1'b1;
    logic [19:0] pa;
    logic code_rd;
    logic [15:0] pdata;
    spr_amode_t mode = SPR_AM_IDX0;
    logic [7:0] doff = 8'h00;
    logic [15:0] daddr;
    logic [1:0] gbank;
    logic irq0 = 1'b0;
    logic irq1 = 1'b0;
    logic take0;
    logic take1;
    logic ovf = 1'b0;
    logic unf = 1'b0;
    logic sexc;
    logic [19:0] link = 20'h0;
    logic crd_seen;
    logic [31:0] sv0;
    logic [31:0] sv1;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;

    spr_row_t rows [9] = '{'{OFS_INDEX_PAGE_HIGH, 8'h12, 8'h12},
        '{OFS_INDEX_OFFSET_LOW0, 8'h34, 8'h34}, '{OFS_INDEX_OFFSET_LOW1, 8'h56, 8'h56},
        '{OFS_LINK_EXT, 8'h05, 8'h05}, '{OFS_LINK_HIGH, 8'hA5, 8'hA5},
        '{OFS_LINK_LOW, 8'h3C, 8'h3C}, '{OFS_SYSTEM_CONTROL_STATUS, 8'h18, 8'h18},
        '{OFS_ALU_STATUS, 8'hFF, 8'h1F}, '{6'h28, 8'h77, 8'h00}};
    // arith, result, carry out, carry into msb, expected alu_status
    logic [18:0] ops [5] = '{{1'b1, 8'h80, 2'h1, 8'h02}, {1'b1, 8'h00, 2'h3, 8'h05},
        {1'b0, 8'h90, 2'h0, 8'h09}, {1'b1, 8'h7F, 2'h2, 8'h0B}, {1'b0, 8'h00, 2'h0, 8'h07}};

    spr_regs dut_u (.CORE_CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_req), .CTL(ctl), .ALU(alu), .PC_IN(pc), .PC_RESTORE(pc_rst),
        .NARROW_PROG_SPACE_N(narrow_n), .PROG_ADDR_OUT(pa), .CODE_RD(code_rd),
        .PROG_DATA(pdata), .ADDR_MODE(mode), .DIRECT_OFFSET(doff), .DATA_ADDR(daddr),
        .GPR_BANK(gbank), .IRQ0_REQ(irq0), .IRQ1_REQ(irq1), .IRQ0_TAKE(take0),
        .IRQ1_TAKE(take1), .STACK_OVF(ovf), .STACK_UNF(unf), .STACK_EXC(sexc));

    spr_core_model mem_u (.clk(clk), .code_rd(code_rd), .link_addr(link), .prog_data(pdata));

    always #50 clk = ~clk;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ceiling well above the roughly 300 cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            $display("wrong value timeout expected end seen hang");
            report_and_stop();
        end
    end

    task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_bit(input string what, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %b seen %b", what, e, g);
        end
    endtask

    // waits on waitrequest however long the slave takes; only the timeout ends it
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        logic pend;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {24'h0, d};
        pend = 1'b1;
        while (pend !== 1'b0) begin
            @(negedge clk);
            pend = wait_req;
            @(posedge clk);
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e, input string what);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk_val(what, {24'h0, e}, q);
    endtask

    task automatic pulse(input logic [5:0] c);
        @(posedge clk);
        ctl <= spr_ctl_t'(c);
        @(negedge clk);
        crd_seen = code_rd;
        @(posedge clk);
        ctl <= '0;
        @(negedge clk);
    endtask

    task automatic alu_op(input logic [10:0] v);
        @(posedge clk);
        alu <= spr_alu_t'({1'b1, v});
        @(posedge clk);
        alu <= '0;
    endtask

    task automatic stack_ev(input logic o, input logic u, input logic e);
        @(posedge clk);
        ovf <= o;
        unf <= u;
        @(posedge clk);
        ovf <= 1'b0;
        unf <= 1'b0;
        @(negedge clk);
        chk_bit("stack exception", e, sexc);
    endtask

    task automatic addr_chk(input spr_amode_t m, input logic [7:0] o, input logic [15:0] e);
        @(posedge clk);
        mode <= m;
        doff <= o;
        @(posedge clk);
        @(negedge clk);
        chk_val("data address", {16'h0, e}, {16'h0, daddr});
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].q, "register row");
        end
        chk_val("gpr bank", 32'h3, {30'h0, gbank});
        $display("test rows done");

        addr_chk(SPR_AM_IDX0, 8'h00, 16'h1234);
        addr_chk(SPR_AM_IDX1, 8'h00, 16'h1256);
        addr_chk(SPR_AM_DIRECT, 8'h9A, 16'h009A);
        wr_reg(OFS_SYSTEM_CONTROL_STATUS, 8'h01);
        addr_chk(SPR_AM_DIRECT, 8'h9A, 16'h129A);
        wr_reg(OFS_SYSTEM_CONTROL_STATUS, 8'h05);
        wr_reg(OFS_INDEX_PAGE_HIGH, 8'hAB);
        wr_reg(OFS_INDEX_OFFSET_LOW0, 8'h07);
        addr_chk(SPR_AM_DIRECT, 8'h9A, 16'hAB9A);
        addr_chk(SPR_AM_IDX0, 8'h00, 16'hAB07);
        wr_reg(OFS_SYSTEM_CONTROL_STATUS, 8'h01);
        rd_chk(OFS_INDEX_PAGE_HIGH, 8'h12, "bank0 page");
        addr_chk(SPR_AM_IDX0, 8'h00, 16'h1234);
        $display("test addressing done");

        @(posedge clk);
        pc <= 20'hABCDE;
        pulse(K_LINK);
        rd_chk(OFS_LINK_EXT, 8'h0A, "link ext");
        rd_chk(OFS_LINK_HIGH, 8'hBC, "link high");
        rd_chk(OFS_LINK_LOW, 8'hDE, "link low");
        pulse(K_RET);
        chk_val("pc restore", 32'hABCDE, {12'h0, pc_rst});
        chk_val("prog addr", 32'hABCDE, {12'h0, pa});
        @(posedge clk);
        narrow_n <= 1'b0;
        pc <= 20'h51234;
        pulse(K_LINK);
        rd_chk(OFS_LINK_EXT, 8'h0A, "link ext kept");
        rd_chk(OFS_LINK_LOW, 8'h34, "link low");
        chk_val("pc restore narrow", 32'h01234, {12'h0, pc_rst});
        chk_val("prog addr narrow", 32'h01234, {12'h0, pa});
        narrow_n <= 1'b1;
        pulse(K_RET);
        chk_val("pc restore wide", 32'hA1234, {12'h0, pc_rst});
        $display("test link done");

        link = 20'hA1234;
        pulse(K_LDI);
        chk_bit("code read", 1'b1, crd_seen);
        chk_val("code addr", 32'hA1234, {12'h0, pa});
        rd_chk(OFS_TABLE_BUF_HIGH, 8'hD1, "table high");
        rd_chk(OFS_TABLE_BUF_LOW, 8'h9B, "table low");
        rd_chk(OFS_LINK_LOW, 8'h35, "link low inc");
        link = 20'hA1235;
        pulse(K_LD);
        rd_chk(OFS_TABLE_BUF_LOW, 8'h9A, "table low");
        rd_chk(OFS_LINK_LOW, 8'h35, "link low held");
        $display("test code load done");

        wr_reg(OFS_SYSTEM_CONTROL_STATUS, 8'hC2);
        irq0 <= 1'b1;
        irq1 <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_val("irq takes", 32'h3, {30'h0, take1, take0});
        wr_reg(OFS_SYSTEM_CONTROL_STATUS, 8'hC0);
        @(posedge clk);
        @(negedge clk);
        chk_val("irq masked", 32'h0, {30'h0, take1, take0});
        wr_reg(OFS_SYSTEM_CONTROL_STATUS, 8'h42);
        @(posedge clk);
        @(negedge clk);
        chk_val("irq0 only", 32'h1, {30'h0, take1, take0});
        wr_reg(OFS_SYSTEM_CONTROL_STATUS, 8'hC2);
        pulse(K_ENT);
        @(posedge clk);
        irq0 <= 1'b0;
        irq1 <= 1'b0;
        bus(1'b0, OFS_SYSTEM_CONTROL_STATUS, 8'h00, sv0);
        bus(1'b0, OFS_ALU_STATUS, 8'h00, sv1);
        chk_val("enable after entry", 32'hC0, sv0);
        wr_reg(OFS_SYSTEM_CONTROL_STATUS, 8'h00);
        wr_reg(OFS_SYSTEM_CONTROL_STATUS, sv0[7:0]);
        wr_reg(OFS_ALU_STATUS, sv1[7:0]);
        pulse(K_IRQ_RETURN_INSTR);
        rd_chk(OFS_SYSTEM_CONTROL_STATUS, 8'hC2, "enable after return");
        $display("test interrupts done");

        wr_reg(OFS_ALU_STATUS, 8'h00);
        foreach (ops[i]) begin
            alu_op(ops[i][18:8]);
            rd_chk(OFS_ALU_STATUS, ops[i][7:0], "alu flags");
        end
        wr_reg(OFS_SYSTEM_CONTROL_STATUS, 8'h00);
        stack_ev(1'b1, 1'b0, 1'b0);
        rd_chk(OFS_ALU_STATUS, 8'h17, "stack fault set");
        wr_reg(OFS_SYSTEM_CONTROL_STATUS, 8'h20);
        stack_ev(1'b0, 1'b1, 1'b1);
        alu_op({1'b0, 8'h01, 2'h0});
        rd_chk(OFS_ALU_STATUS, 8'h13, "stack fault kept");
        wr_reg(OFS_ALU_STATUS, 8'h00);
        rd_chk(OFS_ALU_STATUS, 8'h00, "stack fault cleared");
        $display("test flags done");

        // second reset in mid-run must bring every register back to zero
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd_chk(6'(i * 4), 8'h00, "reset value");
        end
        $display("test reset done");
        report_and_stop();
    end
endmodule
